// ---- rfb_top.sv ----
// Receive-side filter clock, frequency error estimator and bit sync.
// Assumes demodulator pins are asynchronous and a register port on mclk.
//
// Operation
// R1: Filter clock is crystal through six-bit divider, then four phases.
// R2: Cutoff is crystal over 80 times divider, 40 with doubler set.
// R3: Filter clock runs at twenty times the cutoff.
// R4: Demodulator up and down pulses feed the estimator.
// R5: Mode 00 off, 01 up, 10 down, 11 up increments down decrements.
// R6: Length field selects 8, 16, 32 or 64 symbols.
// R7: Result register readable at address 16 hex.
// R8: Negative results held in two's complement.
// R9: Controller should prefer the up plus down counting mode.
// R10: Receive with sync enable set outputs recovered clock at bit rate.
// R11: Each received bit is driven on the rising recovered clock edge.
// R12: Controller samples each bit on the falling recovered clock edge.
// R13: Synchronizer clock is sixteen times the bit rate.
// R14: Sync clock is crystal over reference divider times two to 7-shift.
// R15: Reference divider also feeds modulator and bit rate clocks; here only the sync prescaler uses it.
// R16: Synchronizer locks within 22 bits from packet start.
// R17: Sync enable clear passes received data straight to the pin.
// R18: Control write clears counter and restarts; result holds at the end.
`timescale 1ns/10ps
`default_nettype none
module rfb_top (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Register port
   input  wire logic       reg_wr,
   input  wire logic [6:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   // Demodulator pins
   input  wire logic       demod_up_pin,
   input  wire logic       demod_dn_pin,
   input  wire logic       demod_data_pin,
   // Filter clock phases
   output logic            filter_phi1,
   output logic            filter_phi2,
   // Data interface
   output logic            recovered_bit_clock,
   output logic            serial_data_pin_o,
   output logic            serial_data_pin_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic is_rx(input logic [7:0] mode_reg);
      is_rx = (mode_reg[rfb_pkg::MODE_LSB +: 2] == rfb_pkg::MODE_RX);
   endfunction : is_rx

   function automatic logic [6:0] sym_len(input logic [1:0] code);
      sym_len = 7'h08 << code;
   endfunction : sym_len

   function automatic logic [7:0] fee_step(input logic [1:0] mode,
                                           input logic up,
                                           input logic dn);
      logic [7:0] s;
      s = 8'h00;
      case (mode)
         rfb_pkg::FEE_UP:   s = up ? 8'h01 : 8'h00;
         rfb_pkg::FEE_DN:   s = dn ? 8'hff : 8'h00;
         rfb_pkg::FEE_BOTH: s = (up ? 8'h01 : 8'h00) + (dn ? 8'hff : 8'h00);
         default:           s = 8'h00;
      endcase
      fee_step = s;
   endfunction : fee_step

   ////////////////////////////////////////////////////////////////////////
   // Register file

   logic [7:0] mode_ctrl_q;
   logic [7:0] filt_mod_q;
   logic [7:0] clk_sel_a_q;
   logic [7:0] clk_sel_b_q;
   logic [7:0] filt_div_q;
   logic [7:0] fee_ctrl_q;
   logic [7:0] fee_result_q;
   logic       fee_wr;

   assign fee_wr = reg_wr && (reg_addr == rfb_pkg::A_FEE_CTRL);

   // Writable registers; result is read only
   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_ctrl_q <= rfb_pkg::RESET_VALUE;
         filt_mod_q  <= rfb_pkg::RESET_VALUE;
         clk_sel_a_q <= rfb_pkg::RESET_VALUE;
         clk_sel_b_q <= rfb_pkg::RESET_VALUE;
         filt_div_q  <= rfb_pkg::RESET_VALUE;
         fee_ctrl_q  <= rfb_pkg::RESET_VALUE;
      end else if (reg_wr) begin
         case (reg_addr)
            rfb_pkg::A_MODE_CTRL: mode_ctrl_q <= reg_wdata;
            rfb_pkg::A_FILT_MOD:
               filt_mod_q <= reg_wdata & rfb_pkg::FILT_MOD_MASK;
            rfb_pkg::A_CLK_SEL_A: clk_sel_a_q <= reg_wdata;
            rfb_pkg::A_CLK_SEL_B: clk_sel_b_q <= reg_wdata;
            rfb_pkg::A_FILT_DIV:  filt_div_q  <= reg_wdata;
            rfb_pkg::A_FEE_CTRL:
               fee_ctrl_q <= reg_wdata & rfb_pkg::FEE_CTRL_MASK;
            default: ;
         endcase
      end
   end

   // Registered readback, unmapped addresses read zero
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            rfb_pkg::A_MODE_CTRL:  reg_rdata <= mode_ctrl_q;
            rfb_pkg::A_FILT_MOD:   reg_rdata <= filt_mod_q;
            rfb_pkg::A_CLK_SEL_A:  reg_rdata <= clk_sel_a_q;
            rfb_pkg::A_CLK_SEL_B:  reg_rdata <= clk_sel_b_q;
            rfb_pkg::A_FILT_DIV:
               reg_rdata <= filt_div_q | rfb_pkg::FILT_DIV_FIXED;
            rfb_pkg::A_FEE_CTRL:   reg_rdata <= fee_ctrl_q;
            rfb_pkg::A_FEE_RESULT: reg_rdata <= fee_result_q; // R7
            default:               reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and pulse detection

   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_s3_q;
   logic       up_pulse;
   logic       dn_pulse;
   logic       data_edge;

   // Two flops before use, third for edge detection
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
         pin_s3_q <= 3'h0;
      end else begin
         pin_s1_q <= {demod_data_pin, demod_dn_pin, demod_up_pin};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   assign up_pulse  = pin_s2_q[0] && !pin_s3_q[0]; // R4
   assign dn_pulse  = pin_s2_q[1] && !pin_s3_q[1]; // R4
   assign data_edge = pin_s2_q[2] ^ pin_s3_q[2];

   ////////////////////////////////////////////////////////////////////////
   // Switched-capacitor filter clock

   rfb_tick_if filt_div ();
   logic [1:0] fstep_q;

   assign filt_div.period = filt_div_q[rfb_pkg::DIV_W-1:0];

   rfb_divider u_filt_div (
      .mclk (mclk),
      .rst  (rst),
      .div  (filt_div)
   );

   // Four steps per filter period; doubler takes two steps per tick
   always_ff @(posedge mclk) begin
      if (rst) begin
         fstep_q     <= 2'h0;
         filter_phi1 <= 1'b0;
         filter_phi2 <= 1'b0;
      end else if (filt_div.tick) begin
         if (!filt_div_q[rfb_pkg::DOUBLER_BIT]) begin
            fstep_q <= fstep_q + 2'h1; // R1 R3
         end else begin
            fstep_q <= fstep_q + 2'h2; // R2
         end
         filter_phi1 <= (fstep_q == 2'h3) ||
                        (filt_div_q[rfb_pkg::DOUBLER_BIT] &&
                         fstep_q == 2'h2);
         filter_phi2 <= (fstep_q == 2'h1) ||
                        (filt_div_q[rfb_pkg::DOUBLER_BIT] &&
                         fstep_q == 2'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronizer clock: reference divider then 2^(7-shift)

   rfb_tick_if ref_div ();
   logic [rfb_pkg::PRESCALE_W-1:0] pre_q;
   logic [rfb_pkg::SHIFT_W-1:0]    sync_shift;
   logic [rfb_pkg::PRESCALE_W-1:0] pre_mask;
   logic                           sync_tick_q;

   // Shared ratio, also meant for modulator and bit rate clocks
   assign ref_div.period = clk_sel_b_q[rfb_pkg::DIV_W-1:0]; // R15
   assign sync_shift = clk_sel_a_q[rfb_pkg::SYNC_SHIFT_LSB +: 3];
   assign pre_mask   = 7'h7f >> sync_shift;

   rfb_divider u_ref_div (
      .mclk (mclk),
      .rst  (rst),
      .div  (ref_div)
   );

   // Prescaler divides the reference tick by a power of two
   always_ff @(posedge mclk) begin
      if (rst) begin
         pre_q       <= '0;
         sync_tick_q <= 1'b0;
      end else begin
         sync_tick_q <= 1'b0;
         if (ref_div.tick) begin
            pre_q <= pre_q + 7'h01;
            sync_tick_q <= ((pre_q & pre_mask) == pre_mask); // R14 R13
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bit synchronizer: sixteen phases per bit

   logic [rfb_pkg::PHASE_W-1:0] phase_q;
   logic                        edge_seen_q;
   logic                        rx_on;
   logic                        sync_on;
   logic                        sym_tick;

   assign rx_on    = is_rx(mode_ctrl_q);
   assign sync_on  = rx_on && mode_ctrl_q[rfb_pkg::SYNC_EN_BIT];
   assign sym_tick = sync_tick_q && (phase_q == rfb_pkg::PHASE_SAMPLE);

   // Remember an edge until the next slow tick; a new edge wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         edge_seen_q <= 1'b0;
      end else if (data_edge) begin
         edge_seen_q <= 1'b1;
      end else if (sync_tick_q) begin
         edge_seen_q <= 1'b0;
      end
   end

   // Nudge by one phase per edge so noise cannot jerk the clock
   always_ff @(posedge mclk) begin
      if (rst || !rx_on) begin
         phase_q <= rfb_pkg::PHASE_EDGE;
      end else if (sync_tick_q) begin
         if (edge_seen_q && phase_q != rfb_pkg::PHASE_EDGE &&
             phase_q < rfb_pkg::PHASE_SAMPLE) begin
            phase_q <= phase_q; // R16
         end else if (edge_seen_q && phase_q > rfb_pkg::PHASE_SAMPLE) begin
            phase_q <= phase_q + 4'h2; // R16
         end else begin
            phase_q <= phase_q + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sampled bits pass a two-entry buffer to the pin stage

   logic sample_q;
   logic pend_q;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_data;
   logic pop;

   // Mid-bit sample waits while the buffer is full; new sample wins
   always_ff @(posedge mclk) begin
      if (rst || !sync_on) begin
         pend_q   <= 1'b0;
         sample_q <= 1'b0;
      end else if (sym_tick) begin
         pend_q   <= 1'b1;
         sample_q <= pin_s2_q[2];
      end else if (buf_in_ready) begin
         pend_q <= 1'b0;
      end
   end

   // A skip from the last phase jumps over phase 0, so it pops as well
   assign pop = sync_on && sync_tick_q &&
                (phase_q == rfb_pkg::PHASE_EDGE ||
                 (phase_q == rfb_pkg::PHASE_EDGE - 4'h1 &&
                  edge_seen_q)); // R10

   rfb_buffer #(
      .W     (1),
      .DEPTH (2)
   ) u_buf (
      .mclk      (mclk),
      .rst       (rst || !sync_on),
      .in_valid  (pend_q),
      .in_ready  (buf_in_ready),
      .in_data   (sample_q),
      .out_valid (buf_out_valid),
      .out_ready (pop),
      .out_data  (buf_out_data)
   );

   // Clock high for phases 1-8, data changes only with its rise
   always_ff @(posedge mclk) begin
      if (rst) begin
         recovered_bit_clock <= 1'b0;
         serial_data_pin_o   <= 1'b0;
         serial_data_pin_oe  <= 1'b0;
      end else begin
         serial_data_pin_oe <= rx_on;
         if (!sync_on) begin
            recovered_bit_clock <= 1'b0;
            serial_data_pin_o   <= pin_s2_q[2]; // R17
         end else if (pop) begin
            recovered_bit_clock <= 1'b1; // R10
            if (buf_out_valid) begin
               serial_data_pin_o <= buf_out_data; // R11
            end
         end else if (sync_tick_q &&
                      phase_q == rfb_pkg::PHASE_SAMPLE) begin
            recovered_bit_clock <= 1'b0; // R12
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency error estimator

   logic [7:0]             acc_q;
   logic [7:0]             acc_next;
   logic [rfb_pkg::SYM_W-1:0] sym_cnt_q;
   logic                   run_q;

   assign acc_next = acc_q + fee_step(fee_ctrl_q[1:0], up_pulse, dn_pulse);

   // Write restarts; result latches when the symbol count is reached
   always_ff @(posedge mclk) begin
      if (rst) begin
         acc_q        <= 8'h00;
         sym_cnt_q    <= '0;
         run_q        <= 1'b0;
         fee_result_q <= 8'h00;
      end else if (fee_wr) begin
         acc_q     <= 8'h00; // R18
         sym_cnt_q <= '0;
         run_q     <= (reg_wdata[1:0] != rfb_pkg::FEE_OFF); // R5
      end else if (run_q) begin
         acc_q <= acc_next; // R5 R8
         if (sym_tick) begin
            sym_cnt_q <= sym_cnt_q + 7'h01;
            if (sym_cnt_q + 7'h01 == sym_len(fee_ctrl_q[3:2])) begin // R6
               fee_result_q <= acc_next; // R18
               run_q        <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   phases_excl_a: assert property (@(posedge mclk) disable iff (rst)
      !(filter_phi1 && filter_phi2)) // R1
      else $error("filter phases overlap");

   phase_tick_a: assert property (@(posedge mclk) disable iff (rst)
      ($changed(filter_phi1) || $changed(filter_phi2)) |->
      $past(filt_div.tick)) // R2
      else $error("filter phase moved without divider tick");

   sync_ref_a: assert property (@(posedge mclk) disable iff (rst)
      sync_tick_q |-> $past(ref_div.tick)) // R14
      else $error("sync tick without reference tick");

   fee_clear_a: assert property (@(posedge mclk) disable iff (rst)
      fee_wr |=> (acc_q == 8'h00 && sym_cnt_q == '0)) // R18
      else $error("estimator not cleared by control write");

   result_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (!run_q && !fee_wr) |=> $stable(fee_result_q)) // R18
      else $error("result changed while idle");

   fee_off_a: assert property (@(posedge mclk) disable iff (rst)
      (fee_wr && reg_wdata[1:0] == rfb_pkg::FEE_OFF) |=> !run_q) // R5
      else $error("off mode started a measurement");

   up_only_a: assert property (@(posedge mclk) disable iff (rst)
      (run_q && !fee_wr && fee_ctrl_q[1:0] == rfb_pkg::FEE_UP &&
       dn_pulse && !up_pulse) |=> $stable(acc_q)) // R5
      else $error("up mode counted a down pulse");

   down_neg_a: assert property (@(posedge mclk) disable iff (rst)
      (run_q && !fee_wr && fee_ctrl_q[1:0] == rfb_pkg::FEE_DN &&
       dn_pulse) |=> acc_q == $past(acc_q) - 8'h01) // R8
      else $error("down pulse not decremented");

   data_on_rise_a: assert property (@(posedge mclk) disable iff (rst)
      ($past(sync_on) && sync_on && $changed(serial_data_pin_o)) |->
      $rose(recovered_bit_clock)) // R11
      else $error("data changed away from clock rise");

   clk_fall_a: assert property (@(posedge mclk) disable iff (rst)
      ($fell(recovered_bit_clock) && $past(sync_on)) |->
      $past(phase_q) == rfb_pkg::PHASE_SAMPLE) // R10
      else $error("recovered clock fell at wrong phase");

   transparent_a: assert property (@(posedge mclk) disable iff (rst)
      (rx_on && !sync_on) |=> serial_data_pin_o == $past(pin_s2_q[2])) // R17
      else $error("transparent data not passed");

   done_c: cover property (@(posedge mclk) disable iff (rst)
      $fell(run_q) && !$past(fee_wr));
   bit_out_c: cover property (@(posedge mclk) disable iff (rst)
      pop && buf_out_valid);
   buf_full_c: cover property (@(posedge mclk) disable iff (rst)
      pend_q && !buf_in_ready);

endmodule : rfb_top
`default_nettype wire

// ---- rfb_pkg.sv ----
// Constants for the receive-side frequency error and bit sync block.
// Assumes one 40 MHz clock; all offsets are 7-bit register addresses.
package rfb_pkg;

   // Register addresses
   localparam logic [6:0] A_MODE_CTRL   = 7'h00;
   localparam logic [6:0] A_FILT_MOD    = 7'h01;
   localparam logic [6:0] A_CLK_SEL_A   = 7'h06;
   localparam logic [6:0] A_CLK_SEL_B   = 7'h07;
   localparam logic [6:0] A_FILT_DIV    = 7'h08;
   localparam logic [6:0] A_FEE_CTRL    = 7'h15;
   localparam logic [6:0] A_FEE_RESULT  = 7'h16;

   // Field positions and widths
   localparam int         SYNC_EN_BIT   = 3;
   localparam int         MODE_LSB      = 1;
   localparam logic [1:0] MODE_RX       = 2'h2;
   localparam int         DOUBLER_BIT   = 6;
   localparam int         DIV_W         = 6;
   localparam int         SHIFT_W       = 3;
   localparam int         SYNC_SHIFT_LSB = 1;
   localparam logic [7:0] FILT_DIV_FIXED = 8'h80;
   localparam logic [7:0] FILT_MOD_MASK  = 8'hcf;
   localparam logic [7:0] FEE_CTRL_MASK  = 8'h0f;
   localparam logic [7:0] RESET_VALUE    = 8'h00;

   // Estimator modes
   localparam logic [1:0] FEE_OFF       = 2'h0;
   localparam logic [1:0] FEE_UP        = 2'h1;
   localparam logic [1:0] FEE_DN        = 2'h2;
   localparam logic [1:0] FEE_BOTH      = 2'h3;

   // Bit synchronizer timing
   localparam int         PRESCALE_W    = 7;
   localparam int         PHASE_W       = 4;
   localparam logic [3:0] PHASE_EDGE    = 4'h0;
   localparam logic [3:0] PHASE_SAMPLE  = 4'h8;
   localparam int         SYM_W         = 7;
   localparam int         FILT_STEPS    = 4;

endpackage : rfb_pkg

// ---- rfb_tick_if.sv ----
// Carrier between the top and a programmable divider.
// Assumes the same clock on both sides.
`timescale 1ns/10ps
`default_nettype none
interface rfb_tick_if;
   logic [5:0] period;  // Divide ratio, 0 acts as 1
   logic       tick;    // One-cycle pulse every period cycles
   modport src  (input period, output tick);
   modport sink (output period, input tick);
endinterface : rfb_tick_if
`default_nettype wire

// ---- rfb_divider.sv ----
// Programmable divider producing a one-cycle enable pulse.
// Assumes period is steady from the top's register file.
`timescale 1ns/10ps
`default_nettype none
module rfb_divider (
   // Clock and reset
   input  wire logic     mclk,
   input  wire logic     rst,
   // Divider port
   rfb_tick_if.src       div
);
   logic [5:0] cnt_q;
   logic [5:0] last;

   // Zero would wrap to a divide by 64, so it divides by one
   assign last = (div.period == 6'h00) ? 6'h00 : div.period - 6'h01;

   // Count up through the period, pulse on wrap
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q    <= 6'h00;
         div.tick <= 1'b0;
      end else if (cnt_q >= last) begin
         cnt_q    <= 6'h00;
         div.tick <= 1'b1;
      end else begin
         cnt_q    <= cnt_q + 6'h01;
         div.tick <= 1'b0;
      end
   end
endmodule : rfb_divider
`default_nettype wire

// ---- rfb_buffer.sv ----
// Small FIFO with valid and ready on both sides.
// Assumes the source holds data while valid and not ready.
`timescale 1ns/10ps
`default_nettype none
module rfb_buffer #(
   parameter int W     = 1,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage, written only on push
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + PW'(1);
         end
         if (pop) begin
            rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + PW'(1);
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : rfb_buffer
`default_nettype wire

// ---- rfb_mcu_model.sv ----
// Controller model on the far side of the receive data interface.
// Assumes clock and data come straight from the device data pins.
`timescale 1ns/10ps
`default_nettype none
module rfb_mcu_model (
   // Device data interface
   input  wire logic bit_clk,
   input  wire logic data,
   input  wire logic data_oe
);
   logic [63:0] rx_sr_q = '0;

   // Sample on the falling edge, half a bit after the device moved data
   always @(negedge bit_clk) begin
      if (data_oe) begin
         rx_sr_q <= {rx_sr_q[62:0], data};
      end
   end
endmodule : rfb_mcu_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench: registers, filter phases, estimator, bit sync.
// Assumes rfb_pkg, rfb_top and rfb_mcu_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
   bad_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
   logic        mclk, rst, reg_wr, up, dn, din, hit;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [47:0] pat;
   wire logic [7:0] reg_rdata;
   wire logic   phi1, phi2, bclk, dout, doe;
   int          bad_count, checks;
   int          cyc = 0;

   rfb_top i_dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .demod_up_pin(up), .demod_dn_pin(dn), .demod_data_pin(din),
      .filter_phi1(phi1), .filter_phi2(phi2), .recovered_bit_clock(bclk),
      .serial_data_pin_o(dout), .serial_data_pin_oe(doe));
   rfb_mcu_model i_mcu (.bit_clk(bclk), .data(dout), .data_oe(doe));

   ////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Hang guard, far above the expected run of about 2500 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end

   // Filter phases must never overlap
   always @(negedge mclk) begin
      if (!rst) `CHK("phase overlap", 1'b0, phi1 & phi2)
   end

   ////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   // One-cycle write strobe, launched and dropped off the sampling edge
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr

   // Readback is registered, so allow two full cycles past the address
   task automatic rdc(input logic [6:0] a, input logic [7:0] e,
                      input string nm);
      @(negedge mclk);
      reg_addr = a;
      repeat (2) @(negedge mclk);
      `CHK(nm, e, reg_rdata)
   endtask : rdc

   // Cycles between two rises of phi1 (0), bit clock (1) or phi2 (2)
   task automatic per(input logic [1:0] s, input logic [7:0] e,
                      input string nm);
      logic a, b;
      int   k, n;
      k = 0;
      n = 0;
      a = (s == 2'h2) ? phi2 : s[0] ? bclk : phi1;
      repeat (3000) begin
         @(posedge mclk);
         #1 b = (s == 2'h2) ? phi2 : s[0] ? bclk : phi1;
         if (!a && b) k++;
         if (k == 1) n++;
         a = b;
         if (k == 2) break;
      end
      `CHK(nm, e, n[7:0])
   endtask : per

   // Five up then three down pulses; result checked early, mid, late
   task automatic est(input logic [7:0] ctl, input logic [7:0] e,
                      input logic [7:0] prev);
      wr(rfb_pkg::A_FEE_CTRL, ctl);
      for (int i = 0; i < 8; i++) begin
         if (i < 5) up = 1'b1;
         else dn = 1'b1;
         repeat (2) @(negedge mclk);
         up = 1'b0;
         dn = 1'b0;
         repeat (2) @(negedge mclk);
      end
      rdc(rfb_pkg::A_FEE_RESULT, prev, "result early");
      repeat (150) @(negedge mclk);
      rdc(rfb_pkg::A_FEE_RESULT, (ctl[3:2] == 2'h0) ? e : prev,
          "result mid");
      repeat (150) @(negedge mclk);
      rdc(rfb_pkg::A_FEE_RESULT, e, "result");
      $display("test estimator %h done", ctl);
   endtask : est

   ////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      up = 1'b0;
      dn = 1'b0;
      din = 1'b0;
      bad_count = 0;
      checks = 0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      // Reset values, masked bits, read-only and unmapped places
      rdc(rfb_pkg::A_FILT_DIV, 8'h80, "div reset");
      rdc(rfb_pkg::A_FEE_RESULT, 8'h00, "result reset");
      rdc(7'h30, 8'h00, "unmapped");
      wr(rfb_pkg::A_FILT_MOD, 8'hfe);
      rdc(rfb_pkg::A_FILT_MOD, 8'hce, "filt mod");
      wr(rfb_pkg::A_FEE_CTRL, 8'hf0);
      rdc(rfb_pkg::A_FEE_CTRL, 8'h00, "fee ctrl");
      wr(rfb_pkg::A_FEE_RESULT, 8'h55);
      rdc(rfb_pkg::A_FEE_RESULT, 8'h00, "result ro");
      $display("test registers done");
      // Filter clock, plain and doubled
      wr(rfb_pkg::A_FILT_DIV, 8'h03);
      per(2'h0, 8'd12, "phi normal");
      per(2'h2, 8'd12, "phi2 normal");
      wr(rfb_pkg::A_FILT_DIV, 8'h43);
      per(2'h0, 8'd6, "phi doubled");
      per(2'h2, 8'd6, "phi2 doubled");
      rdc(rfb_pkg::A_FILT_DIV, 8'hc3, "div fixed");
      $display("test filter done");
      // Sync clock at sixteen ticks per bit, then slower settings
      wr(rfb_pkg::A_CLK_SEL_B, 8'h01);
      wr(rfb_pkg::A_CLK_SEL_A, 8'h0e);
      wr(rfb_pkg::A_MODE_CTRL, 8'h0c);
      per(2'h1, 8'd16, "bit clock");
      wr(rfb_pkg::A_CLK_SEL_A, 8'h0c);
      per(2'h1, 8'd32, "bit clock shift");
      wr(rfb_pkg::A_CLK_SEL_B, 8'h02);
      per(2'h1, 8'd64, "bit clock ref");
      wr(rfb_pkg::A_CLK_SEL_B, 8'h01);
      wr(rfb_pkg::A_CLK_SEL_A, 8'h0e);
      $display("test sync clock done");
      // Every estimator mode in turn
      est(8'h01, 8'h05, 8'h00);
      est(8'h02, 8'hfd, 8'h05);
      est(8'h07, 8'h02, 8'hfd);
      est(8'h00, 8'h02, 8'h02);
      // Stream of bits: locks within the first half, checked after
      pat = 48'h5a3c_96e1_c3a5;
      for (int i = 47; i >= 0; i--) begin
         din = pat[i];
         repeat (16) @(negedge mclk);
      end
      repeat (48) @(negedge mclk);
      hit = 1'b0;
      for (int l = 0; l < 6; l++) begin
         if (i_mcu.rx_sr_q[l +: 24] === pat[23:0]) hit = 1'b1;
      end
      `CHK("sync stream", 1'b1, hit)
      $display("test sync stream done");
      // Transparent receive
      wr(rfb_pkg::A_MODE_CTRL, 8'h04);
      din = 1'b1;
      repeat (5) @(negedge mclk);
      `CHK("pass high", 1'b1, dout)
      `CHK("drive on", 1'b1, doe)
      `CHK("clock idle", 1'b0, bclk)
      din = 1'b0;
      repeat (5) @(negedge mclk);
      `CHK("pass low", 1'b0, dout)
      $display("test transparent done");
      close_out();
   end
endmodule : testbench
`default_nettype wire
